// ### logic/adc_serial_result_control.sv
`timescale 1ns/1ns

module adc_serial_result_control #(
  parameter int SYNC_STAGES = 2
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM register slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Serial link from the host
  input wire logic serial_clk,
  input wire logic select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // System shutdown pin
  output logic system_off_n
);

  // ----------------------------------------------------------------
  // Core domain: register file
  // ----------------------------------------------------------------
  logic [15:0] level;            // Software-set analog level in LSB units
  logic [15:0] level_hold;       // Stable copy offered to the link side
  logic level_req;               // Toggles when level_hold is offered
  logic [SYNC_STAGES-1:0] ack_sync; // Link acknowledge synchroniser
  logic [SYNC_STAGES-1:0] cfg_sync; // Config-event toggle synchroniser
  logic [SYNC_STAGES-1:0] sel_sync; // select_n synchroniser
  logic cfg_seen;                // Last config toggle already handled
  logic sel_prev;                // Previous synced select_n
  logic [6:0] cfg_core;          // Last configuration word, core copy
  logic [15:0] cfg_count;        // Configuration words received
  logic shutdown;                // Device shut down
  logic bus_ack;                 // One wait state per access
  // Link domain signals read by the core side
  logic [6:0] cfg_word;
  logic cfg_tgl;
  logic level_ack;

  wire logic new_cfg = cfg_sync[SYNC_STAGES-1] != cfg_seen;
  wire logic sel_fall = sel_prev & ~sel_sync[SYNC_STAGES-1];

  // Every access waits exactly one cycle, then completes
  assign waitrequest = (read | write) & ~bus_ack;

  // Acknowledge pulse for the access under way
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (read | write) & ~bus_ack;
    end
  end

  // Level register written by software
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      level <= adc_link_pkg::LEVEL_RESET;
    end else if (write && bus_ack && address == adc_link_pkg::ADDR_LEVEL) begin
      level <= writedata[15:0];
    end
  end

  // Read data, registered on the wait cycle so they stand for the completing one; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && !bus_ack) begin
      unique case (address)
        adc_link_pkg::ADDR_LEVEL: readdata <= {16'h0000, level};
        adc_link_pkg::ADDR_STATUS: readdata <= {23'h000000, shutdown,
                                                ~sel_sync[SYNC_STAGES-1], cfg_core};
        adc_link_pkg::ADDR_COUNT: readdata <= {16'h0000, cfg_count};
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Handshake: offer a new level only while the previous one is taken,
  // so level_hold never changes while the link side may copy it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      level_hold <= adc_link_pkg::LEVEL_RESET;
      level_req <= 1'b0;
    end else if (level_req == ack_sync[SYNC_STAGES-1] && level != level_hold) begin
      level_hold <= level;
      level_req <= ~level_req;
    end
  end

  // Synchronisers for signals from the link clock and the select pin
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_sync <= '0;
      cfg_sync <= '0;
      sel_sync <= '1;
    end else begin
      ack_sync <= {ack_sync[SYNC_STAGES-2:0], level_ack};
      cfg_sync <= {cfg_sync[SYNC_STAGES-2:0], cfg_tgl};
      sel_sync <= {sel_sync[SYNC_STAGES-2:0], select_n};
    end
  end

  // Config word capture; the word stays still for many link edges
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_seen <= 1'b0;
      cfg_core <= 7'h00;
      cfg_count <= 16'h0000;
    end else if (new_cfg) begin
      cfg_seen <= cfg_sync[SYNC_STAGES-1];
      cfg_core <= cfg_word;
      cfg_count <= cfg_count + 16'h0001;
    end
  end

  // Shutdown state: set by a config with power_save_n zero, cleared by the
  // next falling select_n; a set in the same cycle wins over the clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sel_prev <= 1'b1;
      shutdown <= 1'b0;
      system_off_n <= 1'b1;
    end else begin
      sel_prev <= sel_sync[SYNC_STAGES-1];
      if (new_cfg && !cfg_word[adc_link_pkg::CFG_POWER_SAVE_N]) begin
        shutdown <= 1'b1;
        system_off_n <= 1'b0;
      end else if (sel_fall) begin
        shutdown <= 1'b0;
        system_off_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link domain: persistent state, survives select_n cycles
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] req_sync; // Level request synchroniser
  logic [15:0] level_link;          // Level copy used for conversions

  // Takes the offered level; the link clock only runs in frames, but a
  // frame gives at least eight edges, enough to finish the crossing
  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_sync <= '0;
      level_ack <= 1'b0;
      level_link <= adc_link_pkg::LEVEL_RESET;
    end else begin
      req_sync <= {req_sync[SYNC_STAGES-2:0], level_req};
      if (req_sync[SYNC_STAGES-1] != level_ack) begin
        level_link <= level_hold;
        level_ack <= ~level_ack;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link domain: frame logic; all but cfg_word, cfg_tgl and result cleared whenever select_n is high
  // ----------------------------------------------------------------
  logic started;                 // Start bit seen
  logic cfg_done;                // All configuration bits in
  logic [2:0] cfg_cnt;           // Configuration bits received
  logic [5:0] cfg_shift;         // Partial configuration word
  logic [11:0] result;           // Converted word
  logic [4:0] slot;              // Output slot of the next falling edge
  logic driving;                 // Device owns the data line

  wire logic [6:0] next_cfg = {cfg_shift, serial_in};
  wire logic next_uni = next_cfg[adc_link_pkg::CFG_POLARITY];

  // Converts the level; unipolar counts from span bottom, bipolar is
  // signed about the centre, and both clamp at the span ends
  function automatic logic [11:0] convert(input logic [15:0] lvl, input logic polarity_select);
    logic signed [15:0] s;
    s = signed'(lvl);
    if (polarity_select) begin
      if (s < 16'sh0000) convert = 12'h000;
      else if (s > 16'sh0fff) convert = 12'hfff;
      else convert = lvl[11:0];
    end else begin
      if (s < -16'sh0800) convert = 12'h800;
      else if (s > 16'sh07ff) convert = 12'h7ff;
      else convert = lvl[11:0];
    end
  endfunction : convert

  // Input side, sampled on rising edges
  always_ff @(posedge serial_clk or posedge select_n) begin
    if (select_n) begin
      started <= 1'b0;
      cfg_done <= 1'b0;
      cfg_cnt <= 3'h0;
      cfg_shift <= 6'h00;
    end else if (!started) begin
      started <= serial_in;
    end else if (!cfg_done) begin
      cfg_shift <= next_cfg[5:0];
      cfg_cnt <= cfg_cnt + 3'h1;
      cfg_done <= cfg_cnt == 3'(adc_link_pkg::CFG_BITS - 1);
    end
  end

  // Completed word and conversion result; kept across select_n so the
  // core side can read the word after the frame ends
  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_word <= 7'h7f;
      cfg_tgl <= 1'b0;
      result <= 12'h000;
    end else if (!select_n && started && !cfg_done
                 && cfg_cnt == 3'(adc_link_pkg::CFG_BITS - 1)) begin
      cfg_word <= next_cfg;
      cfg_tgl <= ~cfg_tgl;
      result <= convert(level_link, next_uni);
    end
  end

  wire logic polarity_select = cfg_word[adc_link_pkg::CFG_POLARITY];
  wire logic msb_first_select = cfg_word[adc_link_pkg::CFG_MSB_FIRST];
  wire logic off = ~cfg_word[adc_link_pkg::CFG_POWER_SAVE_N];

  // Output side, changed on falling edges after the configuration word
  always_ff @(negedge serial_clk or posedge select_n) begin
    if (select_n) begin
      slot <= adc_link_pkg::SLOT_NULL;
      driving <= 1'b0;
      serial_out <= 1'b0;
    end else if (cfg_done) begin
      driving <= 1'b1;
      if (slot != adc_link_pkg::SLOT_MAX) begin
        slot <= slot + 5'h01;
      end
      if (slot == adc_link_pkg::SLOT_NULL) begin
        serial_out <= 1'b0;
      end else if (slot <= adc_link_pkg::SLOT_MSB_LAST) begin
        // Shutdown answers with ones in the twelve MSB slots instead of a result
        serial_out <= off ? 1'b1 : result[4'(adc_link_pkg::SLOT_MSB_LAST - slot)];
      end else if (off || msb_first_select) begin
        serial_out <= 1'b0;
      end else if (slot <= adc_link_pkg::SLOT_LSB_LAST) begin
        serial_out <= result[4'(slot - adc_link_pkg::SLOT_MSB_LAST)];
      end else begin
        // After the repeated MSB a bipolar word keeps sending its sign
        serial_out <= polarity_select ? 1'b0 : result[adc_link_pkg::RESULT_BITS-1];
      end
    end
  end

  // Line released at once when select_n rises
  assign serial_out_oe = driving & ~select_n;

endmodule : adc_serial_result_control

// ### shared/adc_link_pkg.sv
package adc_link_pkg;

  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int CFG_BITS = 7;            // Configuration bits after the start bit
  localparam int CFG_SGL_DIFF = 6;        // First bit after start
  localparam int CFG_ODD_SIGN = 5;
  localparam int CFG_SEL1 = 4;
  localparam int CFG_SEL0 = 3;
  localparam int CFG_POLARITY = 2;        // polarity_select
  localparam int CFG_MSB_FIRST = 1;       // msb_first_select
  localparam int CFG_POWER_SAVE_N = 0;    // power_save_n, last bit in
  localparam int RESULT_BITS = 12;        // Result word width
  localparam int LEVEL_BITS = 16;         // Signed analog level written by software

  // Output slot positions counted in falling edges after the config word
  localparam logic [4:0] SLOT_NULL = 5'h00;
  localparam logic [4:0] SLOT_MSB_LAST = 5'h0c;
  localparam logic [4:0] SLOT_LSB_LAST = 5'h17;
  localparam logic [4:0] SLOT_MAX = 5'h1f;

  // ----------------------------------------------------------------
  // Register map (byte addresses, 32-bit words)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_LEVEL = 4'h0;   // Signed input level, read/write
  localparam logic [3:0] ADDR_STATUS = 4'h4;  // Last config, select, shutdown
  localparam logic [3:0] ADDR_COUNT = 4'h8;   // Config words received
  localparam logic [15:0] LEVEL_RESET = 16'h0000;
  localparam int ST_SELECT = 7;               // Status bit: link selected
  localparam int ST_SHUTDOWN = 8;             // Status bit: device in shutdown

endpackage : adc_link_pkg

// ### bench/adc_serial_result_control_assertions.sv
`timescale 1ns/1ns
module adc_serial_result_control_assertions (
  // Bus side
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Link side
  input wire logic serial_clk,
  input wire logic select_n,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic system_off_n
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // -------------------------------------------
  // Steps of a request and of a wake-up
  // -------------------------------------------
  sequence s_req;
    $rose(read || write);
  endsequence
  // Select falls while the shutdown pin is still low
  sequence s_wake;
    $fell(select_n) ##0 !system_off_n;
  endsequence
  a_wait_first: assert property (s_req |-> waitrequest) else $error("no first wait");
  a_wait_once: assert property (s_req |=> !waitrequest) else $error("wait too long");
  a_idle_free: assert property (!(read || write) |-> !waitrequest) else $error("idle wait");
  a_gap_zero: assert property (read && !waitrequest && address[3:2] == 2'h3
    |-> readdata == 32'h0) else $error("unmapped read not zero");
  a_data_holds: assert property (!read |=> $stable(readdata)) else $error("readdata moved");
  a_off_released: assert property (select_n |-> !serial_out_oe)
    else $error("driving while deselected");
  a_null_first: assert property ($rose(serial_out_oe) |-> !serial_out)
    else $error("first bit not null");
  a_off_in_frame: assert property ($fell(system_off_n) |-> !select_n)
    else $error("shutdown outside frame");
  a_off_holds: assert property (!system_off_n && select_n |=> !system_off_n)
    else $error("shutdown pin released early");
  // The clear passes a synchroniser, so a few cycles are allowed
  a_wake_fast: assert property (s_wake |-> ##[1:8] system_off_n)
    else $error("shutdown pin not released");
endmodule : adc_serial_result_control_assertions

bind adc_serial_result_control adc_serial_result_control_assertions u_chk (.*);

// ### bench/serial_host_model.sv
`timescale 1ns/1ns
module serial_host_model (
  // Host-driven lines
  output logic serial_clk,
  output logic select_n,
  output logic serial_in,
  // Device-driven lines
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  // Link clock stands low outside frames
  initial begin
    serial_clk = 1'h0;
    // Update event, so the frame logic always sees its clearing edge
    select_n <= 1'h1;
    serial_in = 1'h0;
  end
  // One 15 ns period: data moves while low, device samples on the rise
  task automatic tick(input logic b);
    serial_clk = 1'h0;
    serial_in = b;
    #7;
    serial_clk = 1'h1;
    #8;
  endtask : tick
  // Whole exchange; got holds 32 bits read after the config word
  task automatic frame(input logic [6:0] cfg, input int lead, output logic [31:0] got,
                       output logic oe_ok);
    int i;
    select_n = 1'h0;
    oe_ok = 1'h1;
    for (i = 0; i < lead; i++) tick(1'h0);
    tick(1'h1);
    for (i = 6; i >= 0; i--) tick(cfg[i]);
    for (i = 31; i >= 0; i--) begin
      serial_clk = 1'h0;
      serial_in = 1'($urandom); // Junk after config must be ignored
      #7;
      oe_ok = oe_ok & serial_out_oe;
      serial_clk = 1'h1;
      got[i] = serial_out; // Taken on the rising edge
      #8;
    end
    serial_clk = 1'h0;
    #7;
    select_n = 1'h1;
    serial_in = ~serial_in;
    #30;
  endtask : frame
endmodule : serial_host_model

// ### bench/adc_serial_result_control_tb.sv
`timescale 1ns/1ns
module adc_serial_result_control_tb;
  logic core_clk, rst_n, read, write, serial_clk, select_n, serial_in;
  logic serial_out, serial_out_oe, system_off_n, waitrequest;
  logic [3:0] address;
  logic [31:0] writedata, readdata, q;
  logic [15:0] prev;
  logic [22:0] corners [8];
  int miscompares, samples_checked, nframes, cycles;

  adc_serial_result_control u_adc_serial_result_control (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .serial_clk(serial_clk),
    .select_n(select_n),
    .serial_in(serial_in),
    .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .system_off_n(system_off_n)
  );
  serial_host_model u_serial_host_model (.serial_clk(serial_clk), .select_n(select_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end
  // Hang guard, far above the run length
  initial cycles = 0;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check32

  // Bus cycle: the request stands until the rising edge that samples
  // waitrequest low; read data are taken at that same edge, then released
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge core_clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'h0);
    r = readdata;
    read <= 1'h0;
    write <= 1'h0;
  endtask : bus

  // Expected 32 bits after the config word: slot 0 is the null bit
  function automatic logic [31:0] expect_bits(logic [6:0] cfg, logic signed [15:0] lv);
    logic [31:0] e;
    logic [11:0] r;
    int i;
    int v;
    v = lv;
    if (cfg[adc_link_pkg::CFG_POLARITY]) v = v < 0 ? 0 : (v > 4095 ? 4095 : v);
    else v = v < -2048 ? -2048 : (v > 2047 ? 2047 : v);
    r = v[11:0];
    e = 32'h0;
    for (i = 1; i < 32; i++) begin
      if (!cfg[0]) e[31-i] = i < 13;
      else if (i < 13) e[31-i] = r[12-i];
      else if (cfg[1]) e[31-i] = 1'h0;
      else if (i < 24) e[31-i] = r[i-12];
      else e[31-i] = !cfg[2] & r[11];
    end
    return e;
  endfunction : expect_bits

  // Write a level, run two frames; the first is checked only when the level is unchanged
  task automatic run_case(input logic [6:0] cfg, input logic [15:0] lv);
    logic [31:0] got;
    logic ok;
    bus(1'h1, adc_link_pkg::ADDR_LEVEL, {16'h0, lv}, q);
    bus(1'h0, adc_link_pkg::ADDR_LEVEL, 32'h0, q);
    check32({16'h0, q[15:0]}, {16'h0, lv}, "level");
    u_serial_host_model.frame(cfg, $urandom_range(3), got, ok);
    if (lv === prev) check32(got, expect_bits(cfg, lv), "first word");
    u_serial_host_model.frame(cfg, $urandom_range(3), got, ok);
    nframes += 2;
    prev = lv;
    check32(got, expect_bits(cfg, lv), "word");
    check32({31'h0, ok}, 32'h1, "drive");
    repeat (4) @(posedge core_clk);
    check32({31'h0, system_off_n}, {31'h0, cfg[0]}, "off pin");
    bus(1'h0, adc_link_pkg::ADDR_STATUS, 32'h0, q);
    check32(q, {23'h0, !cfg[0], 1'h0, cfg}, "status");
    bus(1'h0, adc_link_pkg::ADDR_COUNT, 32'h0, q);
    check32(q, 32'(nframes), "count");
    $display("case cfg %h level %h done", cfg, lv);
  endtask : run_case

  initial begin
    // Update event, so the link-side reset edge is never missed at time zero
    rst_n <= 1'h0;
    read = 1'h0;
    write = 1'h0;
    address = 4'h0;
    writedata = 32'h0;
    prev = 16'h0;
    corners = '{{7'h07, 16'h1000}, {7'h05, 16'hfffb}, {7'h41, 16'hf7ff}, {7'h03, 16'h07ff},
                {7'h71, 16'hffff}, {7'h06, 16'h0abc}, {7'h07, 16'h0abc}, {7'h00, 16'h0abc}};
    repeat (8) @(posedge core_clk);
    rst_n <= 1'h1;
    q = $urandom(81190);
    bus(1'h1, 4'hc, 32'h1234, q);
    bus(1'h0, 4'hc, 32'h0, q);
    check32(q, 32'h0, "unmapped");
    bus(1'h0, adc_link_pkg::ADDR_LEVEL, 32'h0, q);
    check32(q, {16'h0, adc_link_pkg::LEVEL_RESET}, "level reset");
    bus(1'h0, adc_link_pkg::ADDR_COUNT, 32'h0, q);
    check32(q, 32'h0, "count reset");
    $display("register reset test done");
    foreach (corners[k]) run_case(corners[k][22:16], corners[k][15:0]);
    repeat (16) run_case({4'($urandom), 2'($urandom), 1'h1}, 16'($urandom_range(7000) - 2500));
    stop_test();
  end
endmodule : adc_serial_result_control_tb
